// [design/eq_step_timer.sv]
// Programmable step wait timer for one port's equalizer adaptation
`include "rx_eq_map.svh"

module eq_step_timer #(
  parameter int unsigned BASE_CYC = `STEP_WAIT_BASE_CYC
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Control
  input  wire logic       clear,
  input  wire logic [2:0] code,
  // Result
  output logic            expired
);

  logic [`STEP_CNT_W-1:0] cnt_q;
  logic [`STEP_CNT_W-1:0] limit;

  // Each code step doubles the base wait
  assign limit = (`STEP_CNT_W'(BASE_CYC) << code) - `STEP_CNT_W'(1);

  // Compare with >= so a shorter code written mid-wait still expires
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || clear)
    begin
      cnt_q   <= '0;
      expired <= 1'b0;
    end
    else if (cnt_q >= limit)
    begin
      cnt_q   <= '0;
      expired <= 1'b1;
    end
    else
    begin
      cnt_q   <= cnt_q + `STEP_CNT_W'(1);
      expired <= 1'b0;
    end
  end

endmodule : eq_step_timer

// [design/rx_port_adaptive_eq_control.sv]
// Per receive port adaptive equalizer control, readout and back channel error injection
//
// What this block does
// - Each receive port has its own registers; port select steers host accesses.
// - Wait a coded time, 164 us doubling per code, before each equalizer step.
// - With first-lock restart set, the first lock restarts adaptation from zero.
// - Writing the restart bit restarts adaptation from start value; bit self clears.
// - With floor start enabled, adaptation begins at the floor value, not zero.
// - Continuous error bit corrupts one bit in every back channel frame.
// - One-shot error bit corrupts one bit in exactly one back channel frame.
// - Floor start takes the 4-bit floor field, reset 0x2, as start gain.
// - Adaptation wraps back to the start value once it reaches the 4-bit upper limit, reset 0xF.
// - When adaptation is disabled, the fixed stage select values are applied.
`include "rx_eq_map.svh"

module rx_port_adaptive_eq_control
  import rx_eq_pkg::*;
#(
  parameter int unsigned STEP_WAIT_BASE_CYC = `STEP_WAIT_BASE_CYC
) (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  // Register access from the I2C target
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  output logic      [7:0]             reg_rdata,
  output logic                        reg_rvalid,
  // Receiver lock circuit, asynchronous
  input  wire logic [`PORT_COUNT-1:0] lock_raw,
  // Back channel transmitter
  input  wire logic [`PORT_COUNT-1:0] bc_frame_start,
  output logic      [`PORT_COUNT-1:0] bc_error_inject,
  // Equalizer and lock outputs
  output logic      [`PORT_COUNT-1:0] rx_lock,
  output logic [`PORT_COUNT-1:0][5:0] current_equalizer_setting
);

  port_sel_t  sel_q;
  logic [7:0] port_rd [`PORT_COUNT];

  // A write reaches every port whose write enable is set in port select
  function automatic logic port_write(input logic       wr,
                                      input logic [7:0] addr,
                                      input logic [7:0] target,
                                      input logic       en);
    port_write = wr && (addr == target) && en;
  endfunction : port_write

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sel_q.rd_port <= `RST_SEL_RD_PORT;
      sel_q.wr_en   <= `RST_SEL_WR_EN;
    end
    else if (reg_wr && reg_addr == `ADDR_PORT_SEL)
    begin
      sel_q.rd_port <= reg_wdata[`SEL_RD_PORT];
      sel_q.wr_en   <= reg_wdata[`SEL_WR_EN];
    end
  end

  // Read data appears one cycle after the read strobe; unmapped offsets read zero
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        if (reg_addr == `ADDR_PORT_SEL)
        begin
          reg_rdata <= {3'b000, sel_q.rd_port, 2'b00, sel_q.wr_en};
        end
        else
        begin
          reg_rdata <= port_rd[sel_q.rd_port];
        end
      end
    end
  end

  for (genvar p = 0; p < `PORT_COUNT; p++)
  begin : g_port
    eq_ctl_t      ctl_q;
    eq_bypass_t   byp_q;
    eq_limits_t   lim_q;
    adapt_state_t state_q;
    logic         restart_q;
    logic         bc_cont_q;
    logic         bc_once_q;
    logic         bc_armed_q;
    logic         lock_meta_q;
    logic         lock_sync_q;
    logic         first_seen_q;
    logic [3:0]   eq_q;
    logic [3:0]   start_val;
    logic         expired;
    logic         wr_dbg;
    logic         wr_ctl;
    logic         wr_byp;
    logic         wr_lim;

    assign wr_dbg = port_write(reg_wr, reg_addr, `ADDR_DEBUG, sel_q.wr_en[p]);
    assign wr_ctl = port_write(reg_wr, reg_addr, `ADDR_CTL2, sel_q.wr_en[p]);
    assign wr_byp = port_write(reg_wr, reg_addr, `ADDR_BYPASS, sel_q.wr_en[p]);
    assign wr_lim = port_write(reg_wr, reg_addr, `ADDR_LIMITS, sel_q.wr_en[p]);

    assign start_val = ctl_q.floor_start_enable ? lim_q.equalizer_start_floor : 4'h0;

    // Lock comes from another clock domain
    always_ff @(posedge core_clk)
    begin
      if (sys_rst)
      begin
        lock_meta_q <= 1'b0;
        lock_sync_q <= 1'b0;
      end
      else
      begin
        lock_meta_q <= lock_raw[p];
        lock_sync_q <= lock_meta_q;
      end
    end

    always_ff @(posedge core_clk)
    begin
      if (sys_rst)
      begin
        ctl_q.wait_code                 <= `RST_WAIT_CODE;
        ctl_q.first_lock_restart_select <= `RST_FIRST_LOCK;
        ctl_q.floor_start_enable        <= `RST_FLOOR_EN;
        byp_q                           <= eq_bypass_t'(`RST_BYPASS_REG);
        lim_q                           <= eq_limits_t'(`RST_LIMITS_REG);
      end
      else
      begin
        if (wr_ctl)
        begin
          ctl_q.wait_code                 <= reg_wdata[`CTL2_WAIT];
          ctl_q.first_lock_restart_select <= reg_wdata[`CTL2_FIRST_LOCK];
          ctl_q.floor_start_enable        <= reg_wdata[`CTL2_FLOOR_EN];
        end
        if (wr_byp)
        begin
          byp_q <= eq_bypass_t'(reg_wdata);
        end
        if (wr_lim)
        begin
          lim_q <= eq_limits_t'(reg_wdata);
        end
      end
    end

    // Restart reads back as one for a single cycle only
    always_ff @(posedge core_clk)
    begin
      if (sys_rst)
      begin
        restart_q <= 1'b0;
      end
      else
      begin
        restart_q <= wr_ctl && reg_wdata[`CTL2_RESTART];
      end
    end

    // A new arming in the same cycle as a frame survives, so no request is lost
    always_ff @(posedge core_clk)
    begin
      if (sys_rst)
      begin
        bc_cont_q          <= 1'b0;
        bc_once_q          <= 1'b0;
        bc_armed_q         <= 1'b0;
        bc_error_inject[p] <= 1'b0;
      end
      else
      begin
        if (wr_dbg)
        begin
          bc_cont_q <= reg_wdata[`DBG_BC_CONT];
          bc_once_q <= reg_wdata[`DBG_BC_ONCE];
        end
        if (wr_dbg && reg_wdata[`DBG_BC_ONCE])
        begin
          bc_armed_q <= 1'b1;
        end
        else if (bc_frame_start[p])
        begin
          bc_armed_q <= 1'b0;
        end
        bc_error_inject[p] <= bc_frame_start[p] && (bc_cont_q || bc_armed_q);
      end
    end

    eq_step_timer #(
      .BASE_CYC (STEP_WAIT_BASE_CYC)
    ) u_timer (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .clear    (state_q != ST_WAIT),
      .code     (ctl_q.wait_code),
      .expired  (expired)
    );

    // In the wait state lock is judged only at the end of each wait, so a step never trusts a stale lock
    always_ff @(posedge core_clk)
    begin
      if (sys_rst)
      begin
        state_q      <= ST_START;
        eq_q         <= 4'h0;
        first_seen_q <= 1'b0;
      end
      else if (byp_q.adaptation_disable)
      begin
        state_q <= ST_BYPASS;
      end
      else if (restart_q)
      begin
        state_q <= ST_START;
      end
      else
      begin
        case (state_q)
          ST_START:
          begin
            eq_q    <= start_val;
            state_q <= ST_WAIT;
          end
          ST_WAIT:
          begin
            if (expired && lock_sync_q)
            begin
              first_seen_q <= 1'b1;
              if (ctl_q.first_lock_restart_select && !first_seen_q)
              begin
                eq_q <= 4'h0;
              end
              else
              begin
                state_q <= ST_LOCKED;
              end
            end
            else if (expired)
            begin
              if (eq_q >= lim_q.equalizer_upper_limit)
              begin
                eq_q <= start_val;
              end
              else
              begin
                eq_q <= eq_q + 4'h1;
              end
            end
          end
          ST_LOCKED:
          begin
            if (!lock_sync_q)
            begin
              state_q <= ST_WAIT;
            end
          end
          ST_BYPASS:
          begin
            state_q <= ST_START;
          end
          default:
          begin
            state_q <= ST_START;
          end
        endcase
      end
    end

    always_ff @(posedge core_clk)
    begin
      if (sys_rst)
      begin
        current_equalizer_setting[p] <= 6'h00;
        rx_lock[p]                   <= 1'b0;
      end
      else
      begin
        if (byp_q.adaptation_disable)
        begin
          current_equalizer_setting[p] <= {byp_q.stage_hi, byp_q.stage_lo};
        end
        else
        begin
          current_equalizer_setting[p] <= {2'b00, eq_q};
        end
        if (byp_q.lock_waits_for_adaptation)
        begin
          rx_lock[p] <= lock_sync_q && (state_q == ST_LOCKED || state_q == ST_BYPASS);
        end
        else
        begin
          rx_lock[p] <= lock_sync_q;
        end
      end
    end

    always_comb
    begin
      case (reg_addr)
        `ADDR_DEBUG:  port_rd[p] = {6'b00_0000, bc_cont_q, bc_once_q};
        `ADDR_CTL2:   port_rd[p] = {ctl_q.wait_code, ctl_q.first_lock_restart_select,
                                    restart_q, ctl_q.floor_start_enable, 2'b00};
        `ADDR_STATUS: port_rd[p] = {2'b00, current_equalizer_setting[p]};
        `ADDR_BYPASS: port_rd[p] = byp_q;
        `ADDR_LIMITS: port_rd[p] = lim_q;
        default:      port_rd[p] = 8'h00;
      endcase
    end
  end

endmodule : rx_port_adaptive_eq_control

// [pkg/rx_eq_map.svh]
// Register offsets, field positions, reset values and timing counts for the equalizer control
`ifndef RX_EQ_MAP_SVH
`define RX_EQ_MAP_SVH

`define PORT_COUNT          2

// Register offsets
`define ADDR_PORT_SEL       8'h4C
`define ADDR_DEBUG          8'hD0
`define ADDR_CTL2           8'hD2
`define ADDR_STATUS         8'hD3
`define ADDR_BYPASS         8'hD4
`define ADDR_LIMITS         8'hD5

// Port select fields
`define SEL_RD_PORT         4
`define SEL_WR_EN           1:0
`define RST_SEL_RD_PORT     1'b0
`define RST_SEL_WR_EN       2'h1

// Debug fields
`define DBG_BC_CONT         1
`define DBG_BC_ONCE         0

// Control two fields
`define CTL2_WAIT           7:5
`define CTL2_FIRST_LOCK     4
`define CTL2_RESTART        3
`define CTL2_FLOOR_EN       2
`define RST_WAIT_CODE       3'h4
`define RST_FIRST_LOCK      1'b1
`define RST_FLOOR_EN        1'b1

// Bypass and limit register reset values
`define RST_BYPASS_REG      8'h60
`define RST_LIMITS_REG      8'hF2

// Step wait timing
`define CORE_CLK_PERIOD_NS  8
`define STEP_WAIT_BASE_NS   164000
`define STEP_WAIT_BASE_CYC  ((`STEP_WAIT_BASE_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)
`define STEP_CNT_W          22

`endif

// [pkg/rx_eq_pkg.sv]
// Types shared by the receive port equalizer control
package rx_eq_pkg;

  typedef enum logic [1:0]
  {
    ST_START  = 2'b00,
    ST_WAIT   = 2'b01,
    ST_LOCKED = 2'b10,
    ST_BYPASS = 2'b11
  } adapt_state_t;

  typedef struct packed
  {
    logic [2:0] wait_code;
    logic       first_lock_restart_select;
    logic       floor_start_enable;
  } eq_ctl_t;

  // Same layout as the bypass register
  typedef struct packed
  {
    logic [2:0] stage_hi;
    logic       lock_waits_for_adaptation;
    logic [2:0] stage_lo;
    logic       adaptation_disable;
  } eq_bypass_t;

  // Same layout as the limits register
  typedef struct packed
  {
    logic [3:0] equalizer_upper_limit;
    logic [3:0] equalizer_start_floor;
  } eq_limits_t;

  typedef struct packed
  {
    logic       rd_port;
    logic [1:0] wr_en;
  } port_sel_t;

endpackage : rx_eq_pkg

// [verif/bc_link_model.sv]
// Far side model: raw lock level and back channel frame timing
`include "rx_eq_map.svh"

module bc_link_model (
  // Clock
  input wire logic                    core_clk,
  // Device side
  input wire logic [`PORT_COUNT-1:0]  bc_error_inject,
  output logic     [`PORT_COUNT-1:0]  lock_raw,
  output logic     [`PORT_COUNT-1:0]  bc_frame_start
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`PORT_COUNT-1:0] lock_req = '0;
  int                     inj_cnt  = 0;
  initial
  begin
    lock_raw = '0;
    bc_frame_start = '0;
  end
  // Lock moves off the clock edge, like a circuit on its own timing
  always @(lock_req) #3 lock_raw = lock_req;
  always @(posedge core_clk) if (bc_error_inject[0] === 1'b1) inj_cnt++;
  task frames(input int p, input int n);
    repeat (n)
    begin
      @(negedge core_clk) bc_frame_start[p] = 1'b1;
      @(negedge core_clk) bc_frame_start[p] = 1'b0;
      repeat (4) @(negedge core_clk);
    end
  endtask : frames
endmodule : bc_link_model

// [verif/rx_eq_chk.sv]
// Assertion checker for the port equalizer control
`include "rx_eq_map.svh"

module rx_eq_chk (
  // Clock and reset
  input wire logic                         core_clk,
  input wire logic                         sys_rst,
  // Register bus
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [7:0]                   reg_addr,
  input wire logic [7:0]                   reg_wdata,
  input wire logic [7:0]                   reg_rdata,
  input wire logic                         reg_rvalid,
  // Link side
  input wire logic [`PORT_COUNT-1:0]       lock_raw,
  input wire logic [`PORT_COUNT-1:0]       bc_frame_start,
  input wire logic [`PORT_COUNT-1:0]       bc_error_inject,
  input wire logic [`PORT_COUNT-1:0]       rx_lock,
  input wire logic [`PORT_COUNT-1:0][5:0]  current_equalizer_setting
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic rp_q;
  logic rs_q;
  logic unm;
  // Shadow of the read port so status reads can be judged
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      rp_q <= 1'b0;
    else if (reg_wr && reg_addr == `ADDR_PORT_SEL)
      rp_q <= reg_wdata[`SEL_RD_PORT];
  end
  always_ff @(posedge core_clk)
  begin
    rs_q <= reg_wr && reg_addr == `ADDR_CTL2 && reg_wdata[`CTL2_RESTART];
  end
  assign unm = !(reg_addr inside {`ADDR_PORT_SEL, `ADDR_DEBUG, `ADDR_CTL2,
                                  `ADDR_STATUS, `ADDR_BYPASS, `ADDR_LIMITS});

  a_rd_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_no_stray_valid: assert property (!reg_rd |=> !reg_rvalid)
    else $error("valid without read");
  a_unmapped_zero: assert property (reg_rd && unm |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_restart_clears: assert property (reg_rd && reg_addr == `ADDR_CTL2 && !rs_q
    |=> !reg_rdata[3] && reg_rdata[1:0] == 2'h0)
    else $error("restart bit did not clear");
  a_status_view: assert property (reg_rd && reg_addr == `ADDR_STATUS
    ##1 $stable(current_equalizer_setting)
    |-> reg_rdata == {2'b00, current_equalizer_setting[rp_q]})
    else $error("status read wrong");
  a_inject_cause: assert property ((bc_error_inject & ~$past(bc_frame_start)) == '0)
    else $error("inject without frame");
  a_lock_cause: assert property ((rx_lock & ~$past(lock_raw, 3)) == '0)
    else $error("lock without raw lock");
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> rx_lock == '0
    && bc_error_inject == '0 && !reg_rvalid && current_equalizer_setting == '0)
    else $error("outputs not cleared by reset");

  c_restart: cover property (rs_q);
  c_inject: cover property (bc_error_inject[0]);
  c_lock: cover property ($rose(rx_lock[0]));
  c_status: cover property (reg_rd && reg_addr == `ADDR_STATUS);
endmodule : rx_eq_chk

bind rx_port_adaptive_eq_control rx_eq_chk chk (.core_clk, .sys_rst, .reg_wr,
  .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .lock_raw,
  .bc_frame_start, .bc_error_inject, .rx_lock, .current_equalizer_setting);

// [verif/rx_port_adaptive_eq_control_tb.sv]
// Register level tests of the port equalizer control
`include "rx_eq_map.svh"

module rx_port_adaptive_eq_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                        core_clk  = 1'b0;
  logic                        sys_rst   = 1'b1;
  logic                        reg_wr    = 1'b0;
  logic                        reg_rd    = 1'b0;
  logic [7:0]                  reg_addr  = 8'h00;
  logic [7:0]                  reg_wdata = 8'h00;
  logic [7:0]                  reg_rdata;
  logic                        reg_rvalid;
  logic [`PORT_COUNT-1:0]      lock_raw;
  logic [`PORT_COUNT-1:0]      bc_frame_start;
  logic [`PORT_COUNT-1:0]      bc_error_inject;
  logic [`PORT_COUNT-1:0]      rx_lock;
  logic [`PORT_COUNT-1:0][5:0] current_equalizer_setting;
  logic [7:0]                  d;
  int                          num_errors = 0;
  int                          checked    = 0;
  logic [7:0] ra [7] = '{`ADDR_PORT_SEL, `ADDR_DEBUG, `ADDR_CTL2, `ADDR_BYPASS,
                         `ADDR_LIMITS, `ADDR_STATUS, 8'hD1};
  logic [7:0] rv [7] = '{8'h01, 8'h00, 8'h94, 8'h60, 8'hF2, 8'h02, 8'h00};

  always #4 core_clk = ~core_clk;

  // Short base step so a code 0 wait stays a few cycles long
  rx_port_adaptive_eq_control #(.STEP_WAIT_BASE_CYC(8)) uut (.core_clk, .sys_rst,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .lock_raw,
    .bc_frame_start, .bc_error_inject, .rx_lock, .current_equalizer_setting);
  bc_link_model lnk (.core_clk, .bc_error_inject, .lock_raw, .bc_frame_start);

  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge core_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
    for (int i = 0; i < 3 && reg_rvalid !== 1'b1; i++)
      @(posedge core_clk) #1;
    v = reg_rdata;
  endtask : rd
  task rdchk(input logic [7:0] a, input logic [7:0] exp);
    rd(a, d);
    chk(d, exp);
  endtask : rdchk
  task end_of_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    #400000;
    num_errors++;
    end_of_test();
  end

  initial
  begin
    repeat (6) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge core_clk);
    for (int i = 0; i < 7; i++)
      rdchk(ra[i], rv[i]);
    wr(`ADDR_CTL2, 8'h1C);
    repeat (3) @(negedge core_clk);
    rdchk(`ADDR_CTL2, 8'h14);
    rdchk(`ADDR_STATUS, 8'h02);
    repeat (8) @(negedge core_clk);
    rdchk(`ADDR_STATUS, 8'h03);
    // Upper limit kept above the floor, as software must
    wr(`ADDR_LIMITS, 8'h32);
    wr(`ADDR_CTL2, 8'h1C);
    // The new limit of 3 wraps the step back to the floor, so no status read shows more than 3
    repeat (3) @(negedge core_clk);
    for (int i = 0; i < 12; i++)
    begin
      rd(`ADDR_STATUS, d);
      chk({7'h00, d > 8'h03}, 8'h00);
    end
    wr(`ADDR_CTL2, 8'h18);
    repeat (5) @(negedge core_clk);
    rdchk(`ADDR_STATUS, 8'h00);
    wr(`ADDR_LIMITS, 8'hF2);
    wr(`ADDR_CTL2, 8'h1C);
    lnk.lock_req[0] = 1'b1;
    repeat (40) @(negedge core_clk);
    rdchk(`ADDR_STATUS, 8'h00);
    chk({7'h00, rx_lock[0]}, 8'h01);
    lnk.lock_req[0] = 1'b0;
    repeat (6) @(negedge core_clk);
    chk({7'h00, rx_lock[0]}, 8'h00);
    wr(`ADDR_BYPASS, 8'h61);
    repeat (5) @(negedge core_clk);
    rdchk(`ADDR_STATUS, 8'h18);
    wr(`ADDR_BYPASS, 8'h60);
    // Lock mode set: raw lock alone must not report until a step confirms it
    wr(`ADDR_BYPASS, 8'h70);
    lnk.lock_req[0] = 1'b1;
    wr(`ADDR_CTL2, 8'h1C);
    repeat (3) @(negedge core_clk);
    chk({7'h00, rx_lock[0]}, 8'h00);
    repeat (12) @(negedge core_clk);
    chk({7'h00, rx_lock[0]}, 8'h01);
    lnk.lock_req[0] = 1'b0;
    wr(`ADDR_PORT_SEL, 8'h02);
    wr(`ADDR_CTL2, 8'h80);
    rdchk(`ADDR_CTL2, 8'h14);
    wr(`ADDR_PORT_SEL, 8'h12);
    rdchk(`ADDR_CTL2, 8'h80);
    wr(`ADDR_PORT_SEL, 8'h01);
    wr(`ADDR_DEBUG, 8'h01);
    lnk.frames(0, 3);
    chk(lnk.inj_cnt[7:0], 8'h01);
    wr(`ADDR_DEBUG, 8'h02);
    lnk.frames(0, 3);
    chk(lnk.inj_cnt[7:0], 8'h04);
    rdchk(`ADDR_DEBUG, 8'h02);
    end_of_test();
  end
endmodule : rx_port_adaptive_eq_control_tb
